/* core/tlec_pkg.sv */
`default_nettype none
package tlec_pkg;

  // Geometry of the driver bank.
  localparam int unsigned NUM_LEDS     = 10;
  localparam int unsigned CUR_W        = 5;
  localparam int unsigned SENS_W       = 5;

  // Register indices; the printed offsets are not word multiples, so byte address = 4 * index.
  localparam logic [7:0] IDX_LATENCY   = 8'h2e;
  localparam logic [7:0] IDX_WAVEFORM  = 8'h2f;
  localparam logic [7:0] IDX_EFFECT0   = 8'h30;
  localparam logic [7:0] IDX_EFFECT9   = 8'h39;
  localparam logic [7:0] IDX_GLOBAL    = 8'h3e;
  localparam logic [7:0] IDX_DRV0      = 8'h20;
  localparam logic [7:0] IDX_DRV9      = 8'h29;
  localparam logic [7:0] IDX_STATUS    = 8'h3f;

  // Field positions.
  localparam int unsigned WF_DIM_UP_BIT    = 14;
  localparam int unsigned WF_DIM_DOWN_BIT  = 15;
  localparam int unsigned GL_GANG_BIT      = 14;
  localparam int unsigned DRV_SENS_LSB     = 0;
  localparam int unsigned DRV_MIN_LSB      = 5;
  localparam int unsigned DRV_MAX_LSB      = 10;
  localparam int unsigned EFF_MODE_LSB     = 14;
  localparam int unsigned EFF_T1_LSB       = 0;
  localparam int unsigned EFF_T2_LSB       = 7;

  // Reset values.
  localparam logic [15:0] RST_LATENCY  = 16'h0000;
  localparam logic [15:0] RST_WAVEFORM = 16'hc000;
  localparam logic [15:0] RST_EFFECT   = 16'h0000;
  localparam logic [15:0] RST_GLOBAL   = 16'h0000;
  localparam logic [15:0] RST_DRV      = 16'h0000;

  // Timing: one timer count is 1 ms, latency step 5 ms, at 125 MHz.
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned TICK_US          = 1000;
  localparam int unsigned LAT_STEP_MS      = 5;
  localparam int unsigned TICK_CYCLES      = TICK_US * CLK_MHZ;
  localparam logic [16:0] TICK_LAST        = 17'(TICK_CYCLES - 1);
  localparam logic [3:0]  LAT_TICKS_PER    = 4'(LAT_STEP_MS);

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TLEC_DIM   = 2'b00,
    TLEC_FLASH = 2'b01,
    TLEC_PULSE = 2'b10,
    TLEC_RSVD  = 2'b11
  } tlec_mode_e;

  typedef enum logic [1:0] {
    TLEC_IDLE   = 2'b00,
    TLEC_WAIT   = 2'b01,
    TLEC_ACTIVE = 2'b10,
    TLEC_HOLD   = 2'b11
  } tlec_state_e;

  // Per-driver effect configuration.
  typedef struct packed {
    tlec_mode_e mode;
    logic [6:0] t2;
    logic [6:0] t1;
  } tlec_effect_s;

  // Outward drive for the analog current sources.
  typedef struct packed {
    logic [NUM_LEDS-1:0]        enable;
    logic [NUM_LEDS*CUR_W-1:0]  level;
  } tlec_drive_s;

endpackage
`default_nettype wire

/* core/tlec_top.sv */
// Contract
// - Max current is a 5-bit code at 0.25 mA per count; all ones is top.
// - Three effect modes, dimming, flash and pulsate, chosen per effect register.
// - Dimming ramps up on touch start and down on release.
// - Flash and pulsate run only while the touch is asserted.
// - On release, the running flash or pulsate phase, on or off, finishes first.
// - Each driver has its own effect configuration register.
// - Waveforms use three timers, two per driver and one shared.
// - Ramp-up and ramp-down durations are separate per-driver timers.
// - Waveform bit 14 enables touch dimming, bit 15 enables release dimming.
// - Global dimming enables do not affect flash or pulsate drivers.
// - Dimming moves the current in steps of one code, 250 uA.
// - Gang bit 14 of the global register makes any touch light every driver.
// - Waveform bits 7:0 set how long dimming drivers stay active after release; flash and pulsate drivers go idle at once.
// - The active-time value is also the shared flash and pulsate timer.
// - Latency bits 7:0 delay touch-started activity by value times 5 ms.
// - Global bits 9:0 turn each driver on directly, independent of touch.
// - Manual bits reset off; a set bit holds its driver on until cleared.
// - Over-temperature disables the drivers, which recover when it clears.
// - Untouched drivers sit at minimum current; touch moves toward maximum.
// - A 5-bit sensor code in each driver register binds it to a sensor.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tlec_top
  import tlec_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic [31:0]               touch,
  input  wire logic                      over_temp,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output var  tlec_pkg::tlec_drive_s     drive
);
  import tlec_pkg::*;

  // Register storage.
  logic [15:0] lat_q;
  logic [15:0] wave_q;
  logic [15:0] glob_q;
  logic [15:0] eff_q [NUM_LEDS];
  logic [15:0] drv_q [NUM_LEDS];

  // Per-driver engine state.
  tlec_state_e        st_q   [NUM_LEDS];
  logic [CUR_W-1:0]   lvl_q  [NUM_LEDS];
  logic [10:0]        cnt_q  [NUM_LEDS];
  logic [10:0]        slc_q  [NUM_LEDS];
  logic               ph_q   [NUM_LEDS];
  logic [NUM_LEDS-1:0] act_q;

  // Millisecond tick shared by every timer.
  // One shared divider keeps every engine in step and costs a single counter.
  logic [16:0] tick_cnt_q;
  logic        tick;
  assign tick = (tick_cnt_q == TICK_LAST);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 17'h00001;
    end
  end

  // Slice length per step so a ramp of T ms spans the whole level gap.
  // Division truncates, so a short ramp over a wide gap steps once per millisecond.
  function automatic logic [10:0] slice_ms(input logic [6:0] t, input logic [CUR_W-1:0] gap);
    logic [10:0] q;
    q = 11'h000;
    if (gap != '0) begin
      q = 11'(32'(t) / 32'(gap));
    end
    return q;
  endfunction

  // ---------------- AXI4-Lite slave ----------------
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        aw_take;
  logic        w_take;
  logic        wr_go;
  logic [5:0]  wr_idx;
  logic [5:0]  rd_idx;
  logic        wr_hit;
  logic        rd_hit;
  logic [15:0] rd_val;
  logic [15:0] wr_merge;
  logic [15:0] wr_cur;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign wr_go   = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_idx  = aw_addr_q[7:2];
  assign rd_idx  = s_axi_araddr[7:2];

  // Index decode shared by both directions.
  function automatic logic idx_ok(input logic [5:0] i);
    return (8'(i) == IDX_LATENCY) || (8'(i) == IDX_WAVEFORM) || (8'(i) == IDX_GLOBAL) ||
           (8'(i) >= IDX_EFFECT0 && 8'(i) <= IDX_EFFECT9) ||
           (8'(i) >= IDX_DRV0 && 8'(i) <= IDX_DRV9) || (8'(i) == IDX_STATUS);
  endfunction

  function automatic logic [15:0] reg_val(input logic [5:0] i);
    logic [15:0] v;
    v = 16'h0000;
    if (8'(i) == IDX_LATENCY) v = lat_q;
    if (8'(i) == IDX_WAVEFORM) v = wave_q;
    if (8'(i) == IDX_GLOBAL) v = glob_q;
    if (8'(i) == IDX_STATUS) v = {5'h00, over_temp, act_q};
    if (8'(i) >= IDX_EFFECT0 && 8'(i) <= IDX_EFFECT9) v = eff_q[4'(8'(i) - IDX_EFFECT0)];
    if (8'(i) >= IDX_DRV0 && 8'(i) <= IDX_DRV9) v = drv_q[4'(8'(i) - IDX_DRV0)];
    return v;
  endfunction

  // Status is read-only, so a write there is refused with an error response.
  assign wr_hit   = idx_ok(wr_idx) && (8'(wr_idx) != IDX_STATUS);
  assign rd_hit   = idx_ok(rd_idx);
  assign rd_val   = reg_val(rd_idx);
  assign wr_cur   = reg_val(wr_idx);
  assign wr_merge = {w_strb_q[1] ? w_data_q[15:8] : wr_cur[15:8],
                     w_strb_q[0] ? w_data_q[7:0] : wr_cur[7:0]};

  // Address and data are captured independently; the response follows both.
  // Readies return one cycle after the response is taken, spacing back-to-back writes.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_strb_q      <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_q && !aw_take;
      s_axi_wready  <= !w_hold_q && !w_take;
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end
    end
  end

  // Read channel: one read outstanding, data registered.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_val};
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Register writes, one per accepted write; each driver has its own effect register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lat_q  <= RST_LATENCY;
      wave_q <= RST_WAVEFORM;
      glob_q <= RST_GLOBAL;
      for (int i = 0; i < NUM_LEDS; i++) begin
        eff_q[i] <= RST_EFFECT;
        drv_q[i] <= RST_DRV;
      end
    end else if (wr_go && wr_hit) begin
      if (8'(wr_idx) == IDX_LATENCY) lat_q <= wr_merge;
      if (8'(wr_idx) == IDX_WAVEFORM) wave_q <= wr_merge;
      if (8'(wr_idx) == IDX_GLOBAL) glob_q <= wr_merge;
      for (int i = 0; i < NUM_LEDS; i++) begin
        if (8'(wr_idx) == IDX_EFFECT0 + 8'(i)) eff_q[i] <= wr_merge;
        if (8'(wr_idx) == IDX_DRV0 + 8'(i)) drv_q[i] <= wr_merge;
      end
    end
  end

  // ---------------- Touch routing ----------------
  logic [NUM_LEDS-1:0] trig;
  logic                any_touch;
  assign any_touch = |touch;

  // A sensor code picks one touch line; gang lets any touch fire all drivers.
  always_comb begin
    for (int i = 0; i < NUM_LEDS; i++) begin
      trig[i] = glob_q[GL_GANG_BIT] ? any_touch
                                    : touch[drv_q[i][DRV_SENS_LSB +: SENS_W]];
    end
  end

  // ---------------- Per-driver effect engines ----------------
  // Latency, hold and effect timers count milliseconds; each engine runs one state machine.
  for (genvar g = 0; g < NUM_LEDS; g++) begin : g_led
    tlec_effect_s     eff;
    logic [CUR_W-1:0] lo;
    logic [CUR_W-1:0] hi;
    logic             is_dim;
    logic             up_en;
    logic             dn_en;
    logic [10:0]      lat_ms;
    logic [10:0]      hold_ms;
    logic             step_due;
    logic             on_now;
    logic             cyc_end;

    assign eff      = tlec_effect_s'(eff_q[g]);
    assign lo       = drv_q[g][DRV_MIN_LSB +: CUR_W];
    assign hi       = drv_q[g][DRV_MAX_LSB +: CUR_W];
    assign is_dim   = (eff.mode == TLEC_DIM) || (eff.mode == TLEC_RSVD);
    assign up_en    = wave_q[WF_DIM_UP_BIT];
    assign dn_en    = wave_q[WF_DIM_DOWN_BIT];
    assign lat_ms   = 11'(lat_q[7:0]) * 11'(LAT_TICKS_PER);
    assign hold_ms  = 11'(wave_q[7:0]);
    // A slice of zero or one steps on every tick; a slice of N steps every N ticks.
    assign step_due = tick && (cnt_q[g] + 11'h001 >= slc_q[g]);
    assign on_now   = ph_q[g] ? (cnt_q[g] >= 11'(eff.t1)) : (cnt_q[g] >= 11'(wave_q[7:0]));
    assign cyc_end  = tick && ph_q[g] && on_now;

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        st_q[g]  <= TLEC_IDLE;
        lvl_q[g] <= '0;
        cnt_q[g] <= '0;
        slc_q[g] <= '0;
        ph_q[g]  <= 1'b0;
        act_q[g] <= 1'b0;
      end else begin
        unique case (st_q[g])
          // Steps down to minimum with release dimming on, else drops there at once, then rests; a touch starts the latency wait.
          TLEC_IDLE: begin
            act_q[g] <= 1'b0;
            if (lvl_q[g] > lo && is_dim && dn_en && step_due) begin
              lvl_q[g] <= lvl_q[g] - 5'h01;
              cnt_q[g] <= '0;
            end else if (lvl_q[g] != lo && !(is_dim && dn_en && lvl_q[g] > lo)) begin
              lvl_q[g] <= lo;
            end else if (tick) begin
              cnt_q[g] <= cnt_q[g] + 11'h001;
            end
            if (trig[g]) begin
              st_q[g]  <= TLEC_WAIT;
              cnt_q[g] <= '0;
            end
          end
          // Latency delay before the effect starts.
          TLEC_WAIT: begin
            if (!trig[g]) begin
              st_q[g] <= TLEC_IDLE;
            end else if (cnt_q[g] >= lat_ms) begin
              st_q[g]  <= TLEC_ACTIVE;
              act_q[g] <= 1'b1;
              cnt_q[g] <= '0;
              ph_q[g]  <= 1'b1;
              slc_q[g] <= slice_ms(eff.t1, hi - lo);
              if (!is_dim || !up_en || eff.t1 == '0) lvl_q[g] <= hi;
            end else if (tick) begin
              cnt_q[g] <= cnt_q[g] + 11'h001;
            end
          end
          // Touch in effect: ramp up, or run flash and pulsate cycles.
          TLEC_ACTIVE: begin
            if (is_dim) begin
              if (lvl_q[g] < hi && step_due) begin
                lvl_q[g] <= lvl_q[g] + 5'h01;
                cnt_q[g] <= '0;
              end else if (tick) begin
                cnt_q[g] <= cnt_q[g] + 11'h001;
              end
              if (!trig[g]) begin
                st_q[g]  <= TLEC_HOLD;
                cnt_q[g] <= '0;
              end
            end else begin
              // On phase uses the per-driver timer, off phase the shared one.
              if (tick && on_now) begin
                ph_q[g]  <= !ph_q[g];
                cnt_q[g] <= '0;
                lvl_q[g] <= ph_q[g] ? lo : hi;
              end else if (tick) begin
                cnt_q[g] <= cnt_q[g] + 11'h001;
                if (eff.mode == TLEC_PULSE && ph_q[g] && lvl_q[g] < hi) begin
                  lvl_q[g] <= lvl_q[g] + 5'h01;
                end
              end
              if (!trig[g] && (cyc_end || !ph_q[g] && tick && on_now)) begin
                st_q[g]  <= TLEC_HOLD;
                cnt_q[g] <= '0;
                lvl_q[g] <= lo;
              end
            end
          end
          // After release a dimming driver stays active for the active time; flash and pulsate drivers go straight to idle.
          TLEC_HOLD: begin
            if (trig[g]) begin
              st_q[g]  <= TLEC_ACTIVE;
              cnt_q[g] <= '0;
            end else if (is_dim && cnt_q[g] < hold_ms) begin
              if (tick) cnt_q[g] <= cnt_q[g] + 11'h001;
            end else begin
              st_q[g]  <= TLEC_IDLE;
              act_q[g] <= 1'b0;
              cnt_q[g] <= '0;
              slc_q[g] <= slice_ms(eff.t2, hi - lo);
              // A zero ramp-down timer drops to minimum at once, with no per-tick steps.
              if (eff.t2 == '0) lvl_q[g] <= lo;
            end
          end
        endcase
      end
    end
  end

  // Output stage: manual bits force each driver's maximum current, over-temperature blanks everything.
  // Manual drive bypasses the engines, so a manual driver shows no effect while set.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      drive <= '0;
    end else begin
      for (int i = 0; i < NUM_LEDS; i++) begin
        drive.enable[i] <= !over_temp;
        drive.level[i*CUR_W +: CUR_W] <= over_temp ? '0 :
          glob_q[i] ? drv_q[i][DRV_MAX_LSB +: CUR_W] : lvl_q[i];
      end
    end
  end

endmodule
`default_nettype wire

/* verif/tlec_top_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module tlec_top_chk
  import tlec_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  over_temp,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [7:0]            s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire tlec_pkg::tlec_drive_s drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // A stalled answer must keep its payload, or the master would latch a moving value.
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data moved while stalled");
  // Both halves taken together: the registered response is seen two edges later.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address accepted");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  // Indices below the driver bank hold nothing and must be refused.
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[7:2] < 6'h20 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_hot_off: assert property (over_temp [*3] |-> drive == '0)
    else $error("drivers live while hot");
endmodule

bind tlec_top tlec_top_chk u_chk (
  .clk(clk), .reset(reset), .over_temp(over_temp), .drive(drive),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

/* verif/tlec_touch_src.sv */
`timescale 1ns/100ps
`default_nettype none
module tlec_touch_src (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [31:0] want,
  output var  logic [31:0] touch
);
  // Sensor levels change only on a clock edge, as a debounced detector reports them.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      touch <= 32'h0;
    end else begin
      touch <= want;
    end
  end
endmodule
`default_nettype wire

/* verif/touch_led_effect_controller_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module touch_led_effect_controller_bench;
  import tlec_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, over_temp = 1'b0;
  logic [31:0] want = '0, touch, wdata = '0, rdata, rd;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rs;
  tlec_drive_s drive;
  int          fail_count = 0, cmp_count = 0;
  int          model [0:63];

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  tlec_touch_src u_src (.clk(clk), .reset(reset), .want(want), .touch(touch));
  tlec_top DUT (
    .clk(clk), .reset(reset), .touch(touch), .over_temp(over_temp), .drive(drive),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tmo();
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    wrap_up();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Write master; the model only learns values that the slave accepted.
  task automatic wr(input logic [7:0] idx, input logic [15:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= {idx[5:0], 2'b00};
    wdata <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 50) tmo();
    if (r === RESP_OKAY) model[idx[5:0]] = int'(d);
  endtask

  task automatic rdr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= {idx[5:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 50) tmo();
  endtask

  function automatic bit mapped(input int k);
    return (k >= 32 && k <= 41) || (k >= 46 && k <= 57) || k == 62 || k == 63;
  endfunction

  // Levels with zero timers, zero latency and zero active time: each transition is instant.
  function automatic logic [49:0] exp_lv();
    logic [49:0] v;
    int          d, g;
    g = model[62];
    for (int i = 0; i < 10; i++) begin
      d = model[32 + i];
      if (over_temp) v[i*5 +: 5] = 5'h0;
      else if (g[i] || want[d & 31] || (g[14] && want != 0)) v[i*5 +: 5] = 5'(d >> 10);
      else v[i*5 +: 5] = 5'(d >> 5);
    end
    return v;
  endfunction

  task automatic settle(input string what);
    logic [49:0] e;
    int          n;
    @(posedge clk);
    e = exp_lv();
    for (n = 0; n < 300 && drive.level !== e; n++) @(posedge clk);
    chk(32'(drive.level[49:25]), 32'(e[49:25]), what);
    chk(32'(drive.level[24:0]), 32'(e[24:0]), what);
  endtask

  // Main sequence; the watchdog below cuts a hang short.
  initial begin
    void'($urandom(98875));
    foreach (model[k]) model[k] = 0;
    model[47] = int'(RST_WAVEFORM);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 64; k++) begin
      rdr(8'(k), rd, rs);
      chk(rd, mapped(k) ? 32'(model[k]) : 32'h0, "reset read");
      chk(32'(rs), 32'(mapped(k) ? RESP_OKAY : RESP_SLVERR), "read resp");
    end
    wr(8'h00, 16'hffff, rs);
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped write");
    for (int i = 0; i < 10; i++) begin
      wr(8'(32 + i), (16'($urandom) & 16'h7fe7) | (i == 0 ? 16'h7c00 : 16'h0), rs);
      rdr(8'(32 + i), rd, rs);
      chk(rd, 32'(model[32 + i]), "driver cfg");
    end
    settle("idle min");
    // Dimming stays enabled with zero timers, so every change is immediate.
    repeat (6) begin
      want <= $urandom & 32'hff;
      settle("touch");
    end
    want <= 32'h0;
    settle("release");
    wr(8'h3e, 16'h4000, rs);
    want <= 32'h1 << ($urandom % 8);
    settle("gang");
    want <= 32'h0;
    wr(8'h3e, 16'h0021, rs);
    settle("manual on");
    repeat (100) @(posedge clk);
    settle("manual held");
    wr(8'h3e, 16'h0000, rs);
    settle("manual off");
    want <= 32'hff;
    settle("touch all");
    over_temp <= 1'b1;
    settle("hot");
    chk(32'(drive.enable), 32'h0, "hot enable");
    rdr(8'h3f, rd, rs);
    chk(rd, 32'h7ff, "hot status");
    over_temp <= 1'b0;
    settle("cooled");
    wrap_up();
  end

  initial begin
    #700000;
    tmo();
  end
endmodule
`default_nettype wire
